// ===== ecm_pkg.sv
// Package for the Ethernet core management and status port pair.
// Assumes a single 20 MHz clock domain shared by both ends.
package ecm_pkg;
	// ****************************************************************
	// Widths and timing
	// ****************************************************************
	localparam int MGMT_AW        = 16;
	localparam int MGMT_DW        = 32;
	localparam int RCFG_AW        = 11;
	localparam int CLK_PERIOD_NS  = 50;
	localparam int GRST_HOLD_CYC  = 10;
	localparam int RD_LAT_CYC     = 2;
	localparam int RCFG_WAIT_CYC  = 2;
	localparam int STS_SYNC_STAGES = 2;

	// ****************************************************************
	// Management register word offsets
	// ****************************************************************
	localparam logic [15:0] ADDR_SCRATCH  = 16'h0301;
	localparam logic [15:0] ADDR_CONFIG   = 16'h0310;
	localparam logic [15:0] ADDR_LINKSTAT = 16'h0320;
	localparam logic [31:0] SCRATCH_RST   = 32'h0000_0000;
	localparam logic [31:0] CONFIG_RST    = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	localparam int CFG_TX_RST_BIT = 1;
	localparam int CFG_RX_RST_BIT = 2;

	// ****************************************************************
	// Link status field positions
	// ****************************************************************
	localparam int LS_TX_STABLE = 0;
	localparam int LS_BLK_LOCK  = 1;
	localparam int LS_AM_LOCK   = 2;
	localparam int LS_RX_READY  = 3;
	localparam int LS_LFAULT    = 4;
	localparam int LS_RFAULT    = 5;

	// ****************************************************************
	// APB register map of the host controller
	// ****************************************************************
	localparam logic [7:0] APB_CMD    = 8'h00;
	localparam logic [7:0] APB_ADDR   = 8'h04;
	localparam logic [7:0] APB_WDATA  = 8'h08;
	localparam logic [7:0] APB_RDATA  = 8'h0c;
	localparam logic [7:0] APB_STATUS = 8'h10;
	localparam int CMD_GO_BIT   = 0;
	localparam int CMD_WR_BIT   = 1;
	localparam int CMD_RCFG_BIT = 2;
	localparam int CMD_GRST_BIT = 3;
	localparam int CMD_RRST_BIT = 4;
endpackage : ecm_pkg

// ===== ecm_if.sv
// Interface joining the management/status device end and the host end.
// Assumes both parties share i_clk; the bench supplies the clock.
`timescale 1ns/1ns
interface ecm_if;
	import ecm_pkg::*;
	logic                   clk;
	logic                   grst_n;
	logic                   legacy_rst;
	logic [MGMT_AW-1:0]     mgmt_addr;
	logic                   mgmt_read;
	logic                   mgmt_write;
	logic [MGMT_DW-1:0]     mgmt_wdata;
	logic [MGMT_DW-1:0]     mgmt_rdata;
	logic                   mgmt_rvalid;
	logic                   mgmt_wait;
	logic                   rcfg_reset;
	logic [RCFG_AW-1:0]     rcfg_addr;
	logic                   rcfg_read;
	logic                   rcfg_write;
	logic [MGMT_DW-1:0]     rcfg_wdata;
	logic [MGMT_DW-1:0]     rcfg_rdata;
	logic                   rcfg_wait;
	logic                   tx_lanes_stable;
	logic                   rx_block_locked;
	logic                   alignment_marker_locked;
	logic                   rx_ready;
	logic                   local_fault;
	logic                   remote_fault;
	logic                   unidir_en;
	logic                   fault_gen_en;

	modport dev (
		input  clk, grst_n, legacy_rst, mgmt_addr, mgmt_read, mgmt_write, mgmt_wdata,
		       rcfg_reset, rcfg_addr, rcfg_read, rcfg_write, rcfg_wdata,
		output mgmt_rdata, mgmt_rvalid, mgmt_wait, rcfg_rdata, rcfg_wait,
		       tx_lanes_stable, rx_block_locked, alignment_marker_locked, rx_ready,
		       local_fault, remote_fault, unidir_en, fault_gen_en
	);
	modport host (
		input  clk, mgmt_rdata, mgmt_rvalid, mgmt_wait, rcfg_rdata, rcfg_wait,
		       tx_lanes_stable, rx_block_locked, alignment_marker_locked, rx_ready,
		       local_fault, remote_fault, unidir_en, fault_gen_en,
		output grst_n, legacy_rst, mgmt_addr, mgmt_read, mgmt_write, mgmt_wdata,
		       rcfg_reset, rcfg_addr, rcfg_read, rcfg_write, rcfg_wdata
	);
endinterface : ecm_if

// ===== ecm_sync.sv
// Two-flop level synchroniser, one per bit, used for asynchronous link status.
// Assumes the destination clock is i_clk.
`timescale 1ns/1ns
module ecm_sync
	import ecm_pkg::*;
#(
	parameter int WIDTH = 6
) (
	// Clock and control
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire logic             i_ce,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	// ****************************************************************
	// Per-bit synchroniser chain
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_r;
			logic sync_r;
			// First flop feeds only the second flop.
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else if (i_ce) begin
					meta_r <= i_async[g];
					sync_r <= meta_r;
				end
			end
			assign o_sync[g] = sync_r;
		end
	endgenerate
endmodule : ecm_sync

// ===== ecm_dev.sv
// Device end: management register port, reconfiguration port and status outputs.
// Assumes host keeps its own obligations; lane states arrive on user-side inputs.
//
// Overview of operation
// - Management port answers regardless of link state.
// - Management port answers during other core resets.
// - Global reset restores registers, counters keep values.
// - No management answer during global reset.
// - Management port runs on management clock.
// - Host ties legacy management reset low.
// - Host presents sixteen-bit register address.
// - Host uses read/write strobes, 32-bit write data.
// - Device returns read data with valid flag.
// - Wait-request stalls reads only, never writes.
// - Reconfiguration signals synchronous to reconfiguration clock.
// - Reconfiguration reset clears port and registers.
// - Host drives high strobes, 11-bit address, data.
// - Host holds strobe until wait-request drops.
// - Read data valid once wait-request drops.
// - Status outputs asynchronous; receivers must synchronise; here they are registered on i_clk and the host samples them directly.
// - Lanes-stable only when all transmit lanes stable.
// - Block lock only when all lanes locked.
// - Marker lock only when all lanes aligned.
// - Receive ready only when lanes fully aligned.
// - Fault outputs follow detected local, remote faults.
// - Unidirectional indicators reflect build-time support; here unidir_en and fault_gen_en are both FAULT_GEN_EN & UNIDIR_EN.
// - Global reset synchronised inside; hold ten cycles.
// - Global reset drops lanes-stable and receive-ready.
`timescale 1ns/1ns
module ecm_dev
	import ecm_pkg::*;
#(
	parameter int LANES        = 2,
	parameter int RCFG_DEPTH   = 16,
	parameter bit FAULT_GEN_EN = 1'b1,
	parameter bit UNIDIR_EN    = 1'b1,
	parameter int CNT_W        = 32
) (
	// Clock and control
	input  wire logic              i_clk,
	input  wire logic              i_ce,
	// Link carrier
	ecm_if.dev                     bus,
	// Lane state from the transceiver side
	input  wire logic [LANES-1:0]  i_tx_lane_ok,
	input  wire logic [LANES-1:0]  i_blk_lock,
	input  wire logic [LANES-1:0]  i_am_lock,
	input  wire logic              i_deskew_done,
	input  wire logic              i_lfault,
	input  wire logic              i_rfault,
	input  wire logic              i_frame_evt,
	// Core resets seen by the user side
	output logic                   o_tx_core_rst,
	output logic                   o_rx_core_rst,
	output logic [CNT_W-1:0]       o_frame_cnt
);
	// ****************************************************************
	// Global reset synchroniser
	// ****************************************************************
	logic grst_meta_r;
	logic grst_sync_r;
	// Asynchronous active-low reset is brought into the clock domain here.
	always_ff @(posedge i_clk) begin
		grst_meta_r <= ~bus.grst_n;
		grst_sync_r <= grst_meta_r;
	end
	logic in_grst;
	assign in_grst = grst_sync_r;

	// ****************************************************************
	// Management registers
	// ****************************************************************
	logic [MGMT_DW-1:0] scratch_r;
	logic [MGMT_DW-1:0] config_r;
	logic               wr_hit;
	assign wr_hit = bus.mgmt_write & ~in_grst & i_ce;
	// Writable registers; restored by global reset only.
	always_ff @(posedge i_clk) begin
		if (in_grst) begin
			scratch_r <= SCRATCH_RST;
			config_r  <= CONFIG_RST;
		end else if (wr_hit) begin
			if (bus.mgmt_addr == ADDR_SCRATCH)
				scratch_r <= bus.mgmt_wdata;
			if (bus.mgmt_addr == ADDR_CONFIG)
				config_r  <= bus.mgmt_wdata;
		end
	end

	// Soft resets drive the core but never the management port itself.
	always_ff @(posedge i_clk) begin
		if (in_grst) begin
			o_tx_core_rst <= 1'b1;
			o_rx_core_rst <= 1'b1;
		end else if (i_ce) begin
			o_tx_core_rst <= config_r[CFG_TX_RST_BIT];
			o_rx_core_rst <= config_r[CFG_RX_RST_BIT];
		end
	end

	// Statistics counter survives the global reset; only the RX soft reset bit clears it.
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (config_r[CFG_RX_RST_BIT])
				o_frame_cnt <= '0;
			else if (i_frame_evt && !o_rx_core_rst)
				o_frame_cnt <= o_frame_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ****************************************************************
	// Link status
	// ****************************************************************
	logic [5:0] ls_raw;
	logic [5:0] ls_sync;
	assign ls_raw[LS_TX_STABLE] = &i_tx_lane_ok;
	assign ls_raw[LS_BLK_LOCK]  = &i_blk_lock;
	assign ls_raw[LS_AM_LOCK]   = &i_am_lock;
	assign ls_raw[LS_RX_READY]  = (&i_am_lock) & i_deskew_done;
	assign ls_raw[LS_LFAULT]    = i_lfault;
	assign ls_raw[LS_RFAULT]    = i_rfault;
	// Readback copy, synchronised because the lane states are asynchronous.
	ecm_sync #(.WIDTH(6)) u_ls_sync (
		.i_clk   (i_clk),
		.i_srst  (in_grst),
		.i_ce    (i_ce),
		.i_async (ls_raw),
		.o_sync  (ls_sync)
	);

	// Status outputs are registered, forced off in reset.
	always_ff @(posedge i_clk) begin
		if (in_grst) begin
			bus.tx_lanes_stable         <= 1'b0;
			bus.rx_ready                <= 1'b0;
			bus.rx_block_locked         <= 1'b0;
			bus.alignment_marker_locked <= 1'b0;
			bus.local_fault             <= 1'b0;
			bus.remote_fault            <= 1'b0;
		end else if (i_ce) begin
			bus.tx_lanes_stable         <= ls_raw[LS_TX_STABLE] & ~o_tx_core_rst;
			bus.rx_block_locked         <= ls_raw[LS_BLK_LOCK];
			bus.alignment_marker_locked <= ls_raw[LS_AM_LOCK];
			bus.rx_ready                <= ls_raw[LS_RX_READY] & ~o_rx_core_rst;
			bus.local_fault             <= FAULT_GEN_EN & ls_raw[LS_LFAULT];
			bus.remote_fault            <= FAULT_GEN_EN & ls_raw[LS_RFAULT];
		end
	end

	// Build-time indicators.
	always_ff @(posedge i_clk) begin
		bus.unidir_en    <= FAULT_GEN_EN & UNIDIR_EN;
		bus.fault_gen_en <= FAULT_GEN_EN & UNIDIR_EN;
	end

	// ****************************************************************
	// Management read path
	// ****************************************************************
	logic [1:0]         rd_cnt_r;
	logic [MGMT_DW-1:0] rd_mux;
	// Read value mux; link state never blocks an answer.
	always_comb begin
		rd_mux = UNMAPPED_DATA;
		case (bus.mgmt_addr)
			ADDR_SCRATCH:  rd_mux = scratch_r;
			ADDR_CONFIG:   rd_mux = config_r;
			ADDR_LINKSTAT: rd_mux = {26'h0, ls_sync};
			default:       rd_mux = UNMAPPED_DATA;
		endcase
	end

	// Reads wait RD_LAT_CYC cycles; writes are accepted with no stall.
	always_ff @(posedge i_clk) begin
		if (in_grst) begin
			rd_cnt_r        <= 2'h0;
			bus.mgmt_wait   <= 1'b0;
			bus.mgmt_rvalid <= 1'b0;
			bus.mgmt_rdata  <= UNMAPPED_DATA;
		end else if (i_ce) begin
			bus.mgmt_rvalid <= 1'b0;
			if (bus.mgmt_read && !bus.mgmt_rvalid) begin
				if (rd_cnt_r == 2'(RD_LAT_CYC - 1)) begin
					rd_cnt_r        <= 2'h0;
					bus.mgmt_wait   <= 1'b0;
					bus.mgmt_rvalid <= 1'b1;
					bus.mgmt_rdata  <= rd_mux;
				end else begin
					rd_cnt_r      <= rd_cnt_r + 2'h1;
					bus.mgmt_wait <= 1'b1;
				end
			end else begin
				bus.mgmt_wait <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Reconfiguration port
	// ****************************************************************
	logic [MGMT_DW-1:0] rcfg_mem [RCFG_DEPTH];
	logic [1:0]         rcfg_cnt_r;
	logic               rcfg_req;
	logic [$clog2(RCFG_DEPTH)-1:0] rcfg_idx;
	assign rcfg_req = bus.rcfg_read | bus.rcfg_write;
	assign rcfg_idx = bus.rcfg_addr[$clog2(RCFG_DEPTH)-1:0];

	// Handshake: wait-request stays high until the access completes.
	always_ff @(posedge i_clk) begin
		if (bus.rcfg_reset) begin
			rcfg_cnt_r     <= 2'h0;
			bus.rcfg_wait  <= 1'b1;
			bus.rcfg_rdata <= UNMAPPED_DATA;
		end else if (i_ce) begin
			if (rcfg_req && rcfg_cnt_r != 2'(RCFG_WAIT_CYC)) begin
				rcfg_cnt_r    <= rcfg_cnt_r + 2'h1;
				bus.rcfg_wait <= (rcfg_cnt_r != 2'(RCFG_WAIT_CYC - 1));
				if (bus.rcfg_read && rcfg_cnt_r == 2'(RCFG_WAIT_CYC - 1))
					bus.rcfg_rdata <= rcfg_mem[rcfg_idx];
			end else begin
				rcfg_cnt_r    <= 2'h0;
				bus.rcfg_wait <= 1'b1;
			end
		end
	end

	// Register array cleared by reconfiguration reset.
	always_ff @(posedge i_clk) begin
		if (bus.rcfg_reset) begin
			for (int k = 0; k < RCFG_DEPTH; k++)
				rcfg_mem[k] <= UNMAPPED_DATA;
		end else if (i_ce && bus.rcfg_write && rcfg_cnt_r == 2'(RCFG_WAIT_CYC - 1)) begin
			rcfg_mem[rcfg_idx] <= bus.rcfg_wdata;
		end
	end
endmodule : ecm_dev

// ===== ecm_host.sv
// Host end: APB slave taking orders, driving management or reconfig accesses.
// Assumes the device end answers per the shared interface contract.
`timescale 1ns/1ns
module ecm_host
	import ecm_pkg::*;
(
	// Clock and control
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_ce,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Link carrier
	ecm_if.host              bus
);
	typedef enum {ECM_IDLE, ECM_GRST, ECM_MREQ, ECM_RREQ} ecm_state_t;
	ecm_state_t         st_r;
	logic [31:0]        addr_r;
	logic [31:0]        wdata_r;
	logic [31:0]        rdata_r;
	logic [31:0]        cmd_r;
	logic [3:0]         grst_cnt_r;
	logic               apb_wr;
	logic               busy;
	assign apb_wr = i_psel & i_penable & i_pwrite & o_pready & i_ce;
	assign busy   = (st_r != ECM_IDLE);

	// ****************************************************************
	// APB slave: one wait cycle then ready
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0;
		end else if (i_ce) begin
			o_pready  <= i_psel & i_penable & ~o_pready;
			o_pslverr <= 1'b0;
			case (i_paddr)
				APB_CMD:    o_prdata <= cmd_r;
				APB_ADDR:   o_prdata <= addr_r;
				APB_WDATA:  o_prdata <= wdata_r;
				APB_RDATA:  o_prdata <= rdata_r;
				APB_STATUS: o_prdata <= {22'h0, bus.fault_gen_en, bus.unidir_en, bus.remote_fault,
				                         bus.local_fault, bus.rx_ready, bus.alignment_marker_locked,
				                         bus.rx_block_locked, bus.tx_lanes_stable, 1'b0, busy};
				default:    o_prdata <= 32'h0;
			endcase
		end
	end

	// Order registers written by software.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			addr_r  <= 32'h0;
			wdata_r <= 32'h0;
		end else if (apb_wr) begin
			if (i_paddr == APB_ADDR)  addr_r  <= i_pwdata;
			if (i_paddr == APB_WDATA) wdata_r <= i_pwdata;
		end
	end

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r           <= ECM_IDLE;
			cmd_r          <= 32'h0;
			rdata_r        <= 32'h0;
			grst_cnt_r     <= 4'h0;
			bus.grst_n     <= 1'b1;
			bus.legacy_rst <= 1'b0;
			bus.rcfg_reset <= 1'b0;
			bus.mgmt_read  <= 1'b0;
			bus.mgmt_write <= 1'b0;
			bus.mgmt_addr  <= 16'h0;
			bus.mgmt_wdata <= 32'h0;
			bus.rcfg_read  <= 1'b0;
			bus.rcfg_write <= 1'b0;
			bus.rcfg_addr  <= 11'h0;
			bus.rcfg_wdata <= 32'h0;
		end else if (i_ce) begin
			bus.mgmt_write <= 1'b0;
			bus.rcfg_reset <= 1'b0;
			case (st_r)
				ECM_IDLE: begin
					if (apb_wr && i_paddr == APB_CMD && i_pwdata[CMD_GO_BIT]) begin
						cmd_r <= i_pwdata;
						if (i_pwdata[CMD_GRST_BIT]) begin
							bus.grst_n <= 1'b0;
							grst_cnt_r <= 4'h0;
							st_r       <= ECM_GRST;
						end else if (i_pwdata[CMD_RRST_BIT]) begin
							bus.rcfg_reset <= 1'b1;
						end else if (i_pwdata[CMD_RCFG_BIT]) begin
							bus.rcfg_addr  <= addr_r[RCFG_AW-1:0];
							bus.rcfg_wdata <= wdata_r;
							bus.rcfg_write <= i_pwdata[CMD_WR_BIT];
							bus.rcfg_read  <= ~i_pwdata[CMD_WR_BIT];
							st_r           <= ECM_RREQ;
						end else begin
							bus.mgmt_addr  <= addr_r[MGMT_AW-1:0];
							bus.mgmt_wdata <= wdata_r;
							if (i_pwdata[CMD_WR_BIT])
								bus.mgmt_write <= 1'b1;
							else begin
								bus.mgmt_read <= 1'b1;
								st_r          <= ECM_MREQ;
							end
						end
					end
				end
				ECM_GRST: begin
					grst_cnt_r <= grst_cnt_r + 4'h1;
					if (grst_cnt_r == 4'(GRST_HOLD_CYC - 1)) begin
						bus.grst_n <= 1'b1;
						st_r       <= ECM_IDLE;
					end
				end
				// The device raises wait one cycle late, so the read is held until data returns.
				ECM_MREQ: begin
					if (bus.mgmt_rvalid) begin
						bus.mgmt_read <= 1'b0;
						rdata_r       <= bus.mgmt_rdata;
						st_r          <= ECM_IDLE;
					end
				end
				ECM_RREQ: begin
					if (!bus.rcfg_wait) begin
						bus.rcfg_read  <= 1'b0;
						bus.rcfg_write <= 1'b0;
						if (bus.rcfg_read)
							rdata_r <= bus.rcfg_rdata;
						st_r <= ECM_IDLE;
					end
				end
				default: st_r <= ECM_IDLE;
			endcase
		end
	end
endmodule : ecm_host

// ===== ecm_chk_sva.sv
// Checker for the management and status port pair, watching the carrier signals.
// Assumes it is instantiated beside the carrier, one clock, reset is grst_n low.
`timescale 1ns/1ns
module ecm_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic grst_n,
	// Management port
	input wire logic legacy_rst,
	input wire logic mgmt_read,
	input wire logic mgmt_write,
	input wire logic mgmt_rvalid,
	input wire logic mgmt_wait,
	// Reconfiguration port
	input wire logic rcfg_reset,
	input wire logic rcfg_read,
	input wire logic rcfg_write,
	input wire logic rcfg_wait,
	// Status outputs
	input wire logic tx_lanes_stable,
	input wire logic rx_ready,
	input wire logic unidir_en,
	input wire logic fault_gen_en
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	// All checks run on the shared clock; all but the two global-reset checks sleep while the global reset is low.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!grst_n);

	AST_RD_ANSWER: assert property ($rose(mgmt_read) |-> ##[1:3] mgmt_rvalid)
		else $error("read not answered with valid data");
	AST_RVALID_CAUSE: assert property (mgmt_rvalid |-> $past(mgmt_read))
		else $error("read valid without a read");
	AST_WR_NO_WAIT: assert property (mgmt_write |-> !mgmt_wait)
		else $error("write stalled by wait request");
	AST_WAIT_READ_ONLY: assert property (mgmt_wait |-> mgmt_read || $past(mgmt_read))
		else $error("wait request outside a read");
	AST_RCFG_ANSWER: assert property ((rcfg_read || rcfg_write) && rcfg_wait |-> ##[1:3] !rcfg_wait)
		else $error("reconfiguration access never released");
	AST_RCFG_RESET: assert property (rcfg_reset |=> rcfg_wait)
		else $error("reconfiguration port not held in reset");
	AST_GRST_SILENT: assert property (disable iff (1'b0) $fell(grst_n) |-> ##4 (!mgmt_rvalid && !mgmt_wait)[*6])
		else $error("management port answered during global reset");
	AST_GRST_DROP: assert property (disable iff (1'b0) $fell(grst_n) |-> ##4 (!tx_lanes_stable && !rx_ready)[*6])
		else $error("status outputs kept during global reset");
	AST_INDICATORS: assert property (fault_gen_en |-> unidir_en)
		else $error("indicator outputs disagree");
	AST_LEGACY_LOW: assert property (grst_n |-> !legacy_rst)
		else $error("legacy reset not held low");
endmodule : ecm_chk

// ===== eth_core_mgmt_and_status_ports_test.sv
// Self-checking bench: host end driven over APB, device end facing it on the carrier.
// Assumes the package, carrier and both ends are compiled before this file.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module eth_core_mgmt_and_status_ports_test;
	import ecm_pkg::*;
	// ****************************************************************
	// Stimulus signals
	// ****************************************************************
	logic        clk, srst, psel, penable, pwrite, deskew, lfault, rfault, frame_evt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready;
	logic [1:0]  tx_ok, blk, am;
	logic [31:0] frame_cnt;
	int          error_cnt, n_checks;

	// The carrier takes the bench clock; both ends run on it.
	ecm_if ecm_if_i ();
	assign ecm_if_i.clk = clk;
	ecm_dev ecm_dev_i (.i_clk(clk), .i_ce(1'b1), .bus(ecm_if_i.dev), .i_tx_lane_ok(tx_ok),
		.i_blk_lock(blk), .i_am_lock(am), .i_deskew_done(deskew), .i_lfault(lfault),
		.i_rfault(rfault), .i_frame_evt(frame_evt), .o_tx_core_rst(), .o_rx_core_rst(),
		.o_frame_cnt(frame_cnt));
	ecm_host ecm_host_i (.i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(), .bus(ecm_if_i.host));
	ecm_chk ecm_chk_i (.clk(ecm_if_i.clk), .grst_n(ecm_if_i.grst_n), .legacy_rst(ecm_if_i.legacy_rst),
		.mgmt_read(ecm_if_i.mgmt_read), .mgmt_write(ecm_if_i.mgmt_write),
		.mgmt_rvalid(ecm_if_i.mgmt_rvalid), .mgmt_wait(ecm_if_i.mgmt_wait),
		.rcfg_reset(ecm_if_i.rcfg_reset), .rcfg_read(ecm_if_i.rcfg_read),
		.rcfg_write(ecm_if_i.rcfg_write), .rcfg_wait(ecm_if_i.rcfg_wait),
		.tx_lanes_stable(ecm_if_i.tx_lanes_stable), .rx_ready(ecm_if_i.rx_ready),
		.unidir_en(ecm_if_i.unidir_en), .fault_gen_en(ecm_if_i.fault_gen_en));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// Ends the run with the verdict.
	task print_verdict;
		if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict

	// One APB transfer: setup, access held until pready is sampled high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// One management or reconfiguration access ordered through the host registers.
	task mop(input logic [3:0] cmd, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
		logic [31:0] st;
		apb(1'b1, APB_ADDR, {16'h0000, a}, st);
		apb(1'b1, APB_WDATA, d, st);
		apb(1'b1, APB_CMD, {28'h0000000, cmd}, st);
		do apb(1'b0, APB_STATUS, 32'h0000_0000, st); while (st[0] !== 1'b0);
		apb(1'b0, APB_RDATA, 32'h0000_0000, r);
	endtask : mop

	// ****************************************************************
	// Clock, watchdog and test sequence
	// ****************************************************************
	// Free-running bench clock.
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end

	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		error_cnt = 0; n_checks = 0;
		srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		tx_ok = 2'b00; blk = 2'b00; am = 2'b00; deskew = 1'b0; lfault = 1'b0; rfault = 1'b0;
		frame_evt = 1'b0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// The device has no power-on reset: a global reset brings its registers up first.
		apb(1'b1, APB_CMD, 32'h0000_0009, rd);
		repeat (GRST_HOLD_CYC + 8) @(posedge clk);
		// Register traffic while the link is down.
		mop(4'h3, ADDR_SCRATCH, 32'ha5c3_0f1e, rd);
		mop(4'h1, ADDR_SCRATCH, 32'h0, rd);
		`CHK(rd, 32'ha5c3_0f1e)
		mop(4'h1, 16'h0302, 32'h0, rd);
		`CHK(rd, UNMAPPED_DATA)
		// Soft resets on, the port still answers.
		mop(4'h3, ADDR_CONFIG, 32'h0000_0006, rd);
		`CHK({ecm_dev_i.o_rx_core_rst, ecm_dev_i.o_tx_core_rst}, 2'b11)
		mop(4'h1, ADDR_SCRATCH, 32'h0, rd);
		`CHK(rd, 32'ha5c3_0f1e)
		mop(4'h3, ADDR_CONFIG, 32'h0000_0000, rd);
		`CHK({ecm_dev_i.o_rx_core_rst, ecm_dev_i.o_tx_core_rst}, 2'b00)
		// Lanes up, then one lane of each kind missing.
		tx_ok <= 2'b11; blk <= 2'b11; am <= 2'b11; deskew <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK({ecm_if_i.rx_ready, ecm_if_i.alignment_marker_locked, ecm_if_i.rx_block_locked,
			ecm_if_i.tx_lanes_stable}, 4'hf)
		mop(4'h1, ADDR_LINKSTAT, 32'h0, rd);
		`CHK(rd[3:0], 4'hf)
		tx_ok <= 2'b01; blk <= 2'b10;
		repeat (8) @(posedge clk);
		`CHK({ecm_if_i.rx_block_locked, ecm_if_i.tx_lanes_stable}, 2'b00)
		tx_ok <= 2'b11; blk <= 2'b11; am <= 2'b01; deskew <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK({ecm_if_i.rx_ready, ecm_if_i.alignment_marker_locked}, 2'b00)
		am <= 2'b11; deskew <= 1'b1; lfault <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK({ecm_if_i.remote_fault, ecm_if_i.local_fault}, 2'b01)
		lfault <= 1'b0; rfault <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK({ecm_if_i.remote_fault, ecm_if_i.local_fault}, 2'b10)
		`CHK({ecm_if_i.unidir_en, ecm_if_i.fault_gen_en}, 2'b11)
		// Reconfiguration write then read back.
		mop(4'h7, 16'h0005, 32'h1234_abcd, rd);
		mop(4'h5, 16'h0005, 32'h0, rd);
		`CHK(rd, 32'h1234_abcd)
		// Reconfiguration reset clears the stored word.
		apb(1'b1, APB_CMD, 32'h0000_0011, rd);
		mop(4'h5, 16'h0005, 32'h0, rd);
		`CHK(rd, UNMAPPED_DATA)
		// Counted events survive the global reset, registers do not.
		repeat (3) begin
			@(posedge clk) frame_evt <= 1'b1;
			@(posedge clk) frame_evt <= 1'b0;
		end
		@(posedge clk);
		`CHK(frame_cnt, 32'h0000_0003)
		apb(1'b1, APB_CMD, 32'h0000_0009, rd);
		repeat (7) @(posedge clk);
		`CHK({ecm_if_i.rx_ready, ecm_if_i.tx_lanes_stable}, 2'b00)
		repeat (GRST_HOLD_CYC + 8) @(posedge clk);
		mop(4'h1, ADDR_SCRATCH, 32'h0, rd);
		`CHK(rd, SCRATCH_RST)
		mop(4'h1, ADDR_CONFIG, 32'h0, rd);
		`CHK(rd, CONFIG_RST)
		`CHK(frame_cnt, 32'h0000_0003)
		print_verdict();
	end
endmodule : eth_core_mgmt_and_status_ports_test
